// ===== shared/lock_supervisor_defs.vh
// constants for the motor lock fault supervisor
`ifndef LOCK_SUPERVISOR_DEFS_VH
`define LOCK_SUPERVISOR_DEFS_VH

// register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_INT_CLEAR 8'h08
`define REG_INT_ENABLE 8'h0C
`define REG_SPEED_THR 8'h10
`define REG_SYNC_LIMIT 8'h14
`define REG_ABSENT_CFG 8'h18
`define REG_RETRY_CFG 8'h1C
`define REG_PROBE_CFG 8'h20

// control register fields
`define CTRL_MODE_LSB 0
`define CTRL_EN1_BIT 4
`define CTRL_EN2_BIT 5
`define CTRL_EN3_BIT 6
`define CTRL_STARTUP_LSB 8
`define CTRL_CLEAR_BIT 31
`define CTRL_RESET 32'h0000_0000

// status fields
`define ST_CTRL_FAULT 0
`define ST_MOTOR_LOCK 1
`define ST_OVERSPEED 2
`define ST_SYNC_LOSS 3
`define ST_ABSENT 4
`define ST_PROBE_UP 5
`define ST_PROBE_DOWN 6
`define ST_PROBE_RATE 7
`define ST_SHUTDOWN 8

// response and startup method codes
`define MODE_REPORT 4'h8
`define STARTUP_PROBE 2'h2

// power-stage codes
`define STAGE_RUN 3'h4
`define STAGE_ALL_OFF 3'h0
`define STAGE_RECIRC 3'h1
`define STAGE_HIGH_ON 3'h2
`define STAGE_LOW_ON 3'h3

// timing
`define CLK_HZ 20000000
`define PROBE_DIV_10M 2
`define PROBE_DIV_1M 20
`define PROBE_DIV_100K 200
`define PROBE_DIV_10K 2000
`define RETRY_UNIT_MS 1
`define RETRY_UNIT_CYCLES (`CLK_HZ / 1000 * `RETRY_UNIT_MS)

`endif

// ===== hdl/motor_lock_fault_supervisor.v
// motor lock and probe timing fault supervisor with axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
`include "lock_supervisor_defs.vh"

// How it works
// - enabled lock condition raises event, applies response
// - shutdown/retry modes drive fault pin, stage
// - stage codes: off, recirculate, high, low
// - event sets controller, lock, condition flags
// - latched shutdown ends on clear command
// - retry mode resumes after retry period
// - retry expiry clears the lock fault flags, keeps probe flags
// - report mode flags only, clear releases
// - disabled pattern takes no action
// - each detector has its own enable
// - overspeed when speed exceeds threshold
// - sync loss after counted missed crossings
// - absent motor after low current deglitch
// - probe ramps timed by twelve-bit timer
// - ramp-up retries at four slower clocks
// - ramp-down uses same four-step sequence
// - next probe before decay raises fault
// - controller clears latched fault when gone
module motor_lock_fault_supervisor #(
  parameter SPEED_W = 16,
  parameter RETRY_UNIT = `RETRY_UNIT_CYCLES
) (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // axi4-lite slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // motor measurements
  input wire motor_running,
  input wire [SPEED_W-1:0] measured_speed,
  input wire zero_cross_missed,
  input wire [11:0] lowside_current,
  // probe sequence
  input wire probe_start_rampup,
  input wire probe_start_rampdown,
  input wire probe_current_reached,
  input wire probe_current_zero,
  input wire probe_pulse_cmd,
  // outputs
  output reg [2:0] power_stage_state,
  output reg fault_indicator_pin_n,
  output reg [11:0] probe_timer,
  output wire irq
);

  localparam ST_IDLE = 3'b001;
  localparam ST_UP = 3'b010;
  localparam ST_DOWN = 3'b100;
  // divider reloads, one less than the step ratio
  localparam [10:0] DIV_10M = `PROBE_DIV_10M - 1;
  localparam [10:0] DIV_1M = `PROBE_DIV_1M - 1;
  localparam [10:0] DIV_100K = `PROBE_DIV_100K - 1;
  localparam [10:0] DIV_10K = `PROBE_DIV_10K - 1;

  reg [31:0] ctrl;
  reg [31:0] speed_thr;
  reg [31:0] sync_limit;
  reg [31:0] absent_cfg;
  reg [31:0] retry_cfg;
  reg [8:0] status;
  reg [8:0] int_enable;
  reg [1:0] lock_kind;
  reg [15:0] sync_count;
  reg [15:0] absent_count;
  reg [31:0] retry_count;
  reg [2:0] probe_state;
  reg [1:0] probe_step;
  reg [10:0] probe_div;
  reg probe_decaying;
  reg aw_held, w_held;
  reg [7:0] aw_addr;
  reg [31:0] w_data;

  wire [3:0] lock_response_select = ctrl[`CTRL_MODE_LSB+3:`CTRL_MODE_LSB];
  wire overspeed_detect_enable = ctrl[`CTRL_EN1_BIT];
  wire sync_loss_detect_enable = ctrl[`CTRL_EN2_BIT];
  wire absent_motor_detect_enable = ctrl[`CTRL_EN3_BIT];
  wire [1:0] startup_method_select = ctrl[`CTRL_STARTUP_LSB+1:`CTRL_STARTUP_LSB];
  wire [SPEED_W-1:0] overspeed_threshold = speed_thr[SPEED_W-1:0];
  wire [11:0] absent_motor_current_threshold = absent_cfg[11:0];
  wire [15:0] absent_motor_deglitch_time = absent_cfg[31:16];
  wire [15:0] lock_retry_time_sel = retry_cfg[15:0];

  // response groups
  wire mode_disabled = lock_response_select[3] & lock_response_select[0];
  wire mode_latched = lock_response_select[3:2] == 2'b00;
  wire mode_retry = lock_response_select[3:2] == 2'b01;
  wire mode_report = lock_response_select == `MODE_REPORT;
  wire mode_acts = mode_latched | mode_retry | mode_report;

  // detectors
  wire overspeed_lock = overspeed_detect_enable & (measured_speed > overspeed_threshold);
  wire sync_loss_lock = sync_loss_detect_enable & (sync_count >= sync_limit[15:0]);
  wire absent_motor_lock = absent_motor_detect_enable & (absent_count > absent_motor_deglitch_time);
  wire any_lock = overspeed_lock | sync_loss_lock | absent_motor_lock;
  wire motor_lock_event = motor_running & any_lock & mode_acts & ~status[`ST_MOTOR_LOCK];

  wire lock_active = status[`ST_MOTOR_LOCK];
  wire shutdown = status[`ST_SHUTDOWN];
  wire [31:0] lock_retry_period = lock_retry_time_sel * RETRY_UNIT;
  wire retry_expired = shutdown & lock_kind == 2'b01 & retry_count >= lock_retry_period;
  wire fault_clear_bit = ctrl[`CTRL_CLEAR_BIT];
  wire clear_ok = fault_clear_bit & ~any_lock;

  // probe events
  wire probe_tick = probe_div == 11'd0;
  wire probe_overflow = probe_tick & (probe_timer == 12'hFFF);
  wire probe_up_fault = probe_state == ST_UP & probe_overflow & probe_step == 2'd3 & ~probe_current_reached;
  wire probe_down_fault = probe_state == ST_DOWN & probe_overflow & probe_step == 2'd3 & ~probe_current_zero;
  wire probe_rate_fault = probe_decaying & probe_pulse_cmd;

  // axi write
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  wire wr_go = aw_held & w_held & ~s_axi_bvalid;
  wire wr_ctrl = wr_go & aw_addr == `REG_CTRL;
  wire [8:0] sw_clear = (wr_go & aw_addr == `REG_INT_CLEAR) ? w_data[8:0] : 9'h000;

  always @(posedge sys_clk) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      ctrl <= `CTRL_RESET;
      speed_thr <= 32'hFFFF_FFFF;
      sync_limit <= 32'h0000_0010;
      absent_cfg <= 32'h0000_0000;
      retry_cfg <= 32'h0000_0064;
      int_enable <= 9'h000;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
      end
      // clear command is a self-clearing pulse
      ctrl[`CTRL_CLEAR_BIT] <= 1'b0;
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'b00;
        case (aw_addr)
          `REG_CTRL: ctrl <= w_data;
          `REG_INT_ENABLE: int_enable <= w_data[8:0];
          `REG_SPEED_THR: speed_thr <= w_data;
          `REG_SYNC_LIMIT: sync_limit <= w_data;
          `REG_ABSENT_CFG: absent_cfg <= w_data;
          `REG_RETRY_CFG: retry_cfg <= w_data;
          `REG_STATUS, `REG_INT_CLEAR: s_axi_bresp <= 2'b00;
          default: s_axi_bresp <= 2'b10;
        endcase
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // axi read
  always @(posedge sys_clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      case (s_axi_araddr)
        `REG_CTRL: s_axi_rdata <= ctrl;
        `REG_STATUS: s_axi_rdata <= {23'h0, status};
        `REG_INT_CLEAR: s_axi_rdata <= 32'h0000_0000;
        `REG_INT_ENABLE: s_axi_rdata <= {23'h0, int_enable};
        `REG_SPEED_THR: s_axi_rdata <= speed_thr;
        `REG_SYNC_LIMIT: s_axi_rdata <= sync_limit;
        `REG_ABSENT_CFG: s_axi_rdata <= absent_cfg;
        `REG_RETRY_CFG: s_axi_rdata <= retry_cfg;
        `REG_PROBE_CFG: s_axi_rdata <= {20'h0, probe_timer};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // detector counters
  always @(posedge sys_clk) begin
    if (rst) begin
      sync_count <= 16'h0000;
      absent_count <= 16'h0000;
    end else begin
      if (~motor_running)
        sync_count <= 16'h0000;
      else if (zero_cross_missed & sync_count != 16'hFFFF)
        sync_count <= sync_count + 16'h0001;
      if (~motor_running | lowside_current >= absent_motor_current_threshold)
        absent_count <= 16'h0000;
      else if (absent_count != 16'hFFFF)
        absent_count <= absent_count + 16'h0001;
      if (wr_ctrl & w_data[`CTRL_CLEAR_BIT])
        sync_count <= 16'h0000;
    end
  end

  // lock response and status flags; hardware set wins over software clear
  always @(posedge sys_clk) begin
    if (rst) begin
      status <= 9'h000;
      lock_kind <= 2'b00;
      retry_count <= 32'h0000_0000;
      power_stage_state <= `STAGE_RUN;
      fault_indicator_pin_n <= 1'b1;
    end else begin
      if (motor_lock_event) begin
        status[`ST_CTRL_FAULT] <= 1'b1;
        status[`ST_MOTOR_LOCK] <= 1'b1;
        status[`ST_OVERSPEED] <= overspeed_lock;
        status[`ST_SYNC_LOSS] <= sync_loss_lock;
        status[`ST_ABSENT] <= absent_motor_lock;
        lock_kind <= lock_response_select[3:2];
        retry_count <= 32'h0000_0000;
        if (~mode_report) begin
          status[`ST_SHUTDOWN] <= 1'b1;
          fault_indicator_pin_n <= 1'b0;
          case (lock_response_select[1:0])
            2'b00: power_stage_state <= `STAGE_ALL_OFF;
            2'b01: power_stage_state <= `STAGE_RECIRC;
            2'b10: power_stage_state <= `STAGE_HIGH_ON;
            default: power_stage_state <= `STAGE_LOW_ON;
          endcase
        end
      end else if (lock_active) begin
        if (shutdown & lock_kind == 2'b01)
          retry_count <= retry_count + 32'h0000_0001;
        if (retry_expired | (lock_kind != 2'b01 & clear_ok)) begin
          status[`ST_SHUTDOWN:`ST_CTRL_FAULT] <= {status[`ST_SHUTDOWN] & 1'b0, status[7:5], 5'b00000};
          power_stage_state <= `STAGE_RUN;
          fault_indicator_pin_n <= 1'b1;
        end
      end
      if (probe_up_fault) status[`ST_PROBE_UP] <= 1'b1;
      else if (sw_clear[`ST_PROBE_UP] | clear_ok) status[`ST_PROBE_UP] <= 1'b0;
      if (probe_down_fault) status[`ST_PROBE_DOWN] <= 1'b1;
      else if (sw_clear[`ST_PROBE_DOWN] | clear_ok) status[`ST_PROBE_DOWN] <= 1'b0;
      if (probe_rate_fault) status[`ST_PROBE_RATE] <= 1'b1;
      else if (sw_clear[`ST_PROBE_RATE] | clear_ok) status[`ST_PROBE_RATE] <= 1'b0;
    end
  end

  // probe ramp timer: 12 bits, clock stepped down by ten each overflow
  always @(posedge sys_clk) begin
    if (rst) begin
      probe_state <= ST_IDLE;
      probe_step <= 2'd0;
      probe_div <= 11'd0;
      probe_timer <= 12'h000;
      probe_decaying <= 1'b0;
    end else begin
      probe_div <= probe_tick ? 11'd0 : probe_div - 11'd1;
      if (probe_tick) begin
        case (probe_step)
          2'd0: probe_div <= DIV_10M;
          2'd1: probe_div <= DIV_1M;
          2'd2: probe_div <= DIV_100K;
          default: probe_div <= DIV_10K;
        endcase
      end
      case (probe_state)
        ST_IDLE: begin
          if (startup_method_select == `STARTUP_PROBE & probe_start_rampup) begin
            probe_state <= ST_UP;
            probe_step <= 2'd0;
            probe_timer <= 12'h000;
            probe_div <= 11'd0;
          end else if (startup_method_select == `STARTUP_PROBE & probe_start_rampdown) begin
            probe_state <= ST_DOWN;
            probe_step <= 2'd0;
            probe_timer <= 12'h000;
            probe_div <= 11'd0;
            probe_decaying <= 1'b1;
          end
        end
        ST_UP: begin
          if (probe_current_reached)
            probe_state <= ST_IDLE;
          else if (probe_overflow) begin
            probe_timer <= 12'h000;
            if (probe_step == 2'd3) probe_state <= ST_IDLE;
            else probe_step <= probe_step + 2'd1;
          end else if (probe_tick)
            probe_timer <= probe_timer + 12'h001;
        end
        ST_DOWN: begin
          if (probe_current_zero) begin
            probe_state <= ST_IDLE;
            probe_decaying <= 1'b0;
          end else if (probe_overflow) begin
            probe_timer <= 12'h000;
            if (probe_step == 2'd3) begin
              probe_state <= ST_IDLE;
              probe_decaying <= 1'b0;
            end else
              probe_step <= probe_step + 2'd1;
          end else if (probe_tick)
            probe_timer <= probe_timer + 12'h001;
        end
        default: probe_state <= ST_IDLE;
      endcase
    end
  end

  assign irq = |(status & int_enable);

endmodule
`default_nettype wire

// ===== sim/lock_supervisor_checker_assertions.sv
// port-level assertions for the motor lock fault supervisor
`timescale 1ns/1ps
`default_nettype none
`include "lock_supervisor_defs.vh"
module lock_supervisor_checker (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // fault outputs
  input wire logic [2:0] power_stage_state,
  input wire logic fault_indicator_pin_n,
  input wire logic irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_idle_after_reset: assert property ($fell(rst) |-> power_stage_state == `STAGE_RUN && fault_indicator_pin_n
    && !irq) else $error("outputs not idle after reset");
  a_pin_tracks_stage: assert property (fault_indicator_pin_n == (power_stage_state == `STAGE_RUN))
    else $error("fault pin disagrees with power stage");
  a_stage_code_legal: assert property (power_stage_state <= `STAGE_RUN)
    else $error("illegal power stage code");
  a_stage_held: assert property (power_stage_state != `STAGE_RUN |=>
    power_stage_state == $past(power_stage_state) || power_stage_state == `STAGE_RUN)
    else $error("protective stage changed before release");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write response late");
  a_write_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_no_read_overlap: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answer pending");
endmodule
bind motor_lock_fault_supervisor lock_supervisor_checker chk_u (.sys_clk, .rst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .power_stage_state, .fault_indicator_pin_n, .irq);
`default_nettype wire

// ===== sim/probe_current_model.sv
// gate driver current model for probe ramps
`timescale 1ns/1ps
`default_nettype none
module probe_current_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // ramp commands and settle time
  input wire logic start_up,
  input wire logic start_down,
  input wire logic [15:0] settle,
  // sensed current flags
  output logic reached,
  output logic zero
);
  logic [15:0] cnt;
  always @(posedge sys_clk) begin
    if (rst || start_up || start_down) cnt <= 16'h0000;
    else if (cnt != 16'hFFFF) cnt <= cnt + 16'h0001;
    if (rst) begin
      reached <= 1'b0;
      zero <= 1'b1;
    end else if (start_up) reached <= 1'b0;
    else if (start_down) zero <= 1'b0;
    else if (cnt == settle) begin
      reached <= 1'b1;
      zero <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== sim/motor_lock_fault_supervisor_test.sv
// self-checking bench for the motor lock fault supervisor
`timescale 1ns/1ps
`default_nettype none
`include "lock_supervisor_defs.vh"
module motor_lock_fault_supervisor_test;
  logic sys_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, motor_running, zero_cross_missed;
  logic probe_start_rampup, probe_start_rampdown, probe_current_reached, probe_current_zero, probe_pulse_cmd;
  logic fault_indicator_pin_n, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] measured_speed;
  logic [11:0] lowside_current, probe_timer;
  logic [2:0] power_stage_state;
  int num_errors = 0;
  int n_compared = 0;
  int m;
  motor_lock_fault_supervisor #(.SPEED_W(16), .RETRY_UNIT(2)) dut_u (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .motor_running, .measured_speed, .zero_cross_missed, .lowside_current, .probe_start_rampup,
    .probe_start_rampdown, .probe_current_reached, .probe_current_zero, .probe_pulse_cmd, .power_stage_state,
    .fault_indicator_pin_n, .probe_timer, .irq);
  probe_current_model model_u (.sys_clk, .rst, .start_up(probe_start_rampup), .start_down(probe_start_rampdown),
    .settle(16'h001E), .reached(probe_current_reached), .zero(probe_current_zero));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    int t;
    t = 0;
    tb = 1'b0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!tb) begin
      @(negedge sys_clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid === 1'b1;
      @(posedge sys_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
    end
    chk("write response", 32'h1, {31'h0, tb});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    int t;
    t = 0;
    tr = 1'b0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!tr) begin
      @(negedge sys_clk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid === 1'b1;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge sys_clk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
    end
    chk("read data", e, d);
    chk("read response", {30'h0, er}, {30'h0, r});
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic wst(input logic [2:0] e, input logic pin);
    int t;
    t = 0;
    @(negedge sys_clk);
    while (power_stage_state !== e && t < 80) begin
      @(negedge sys_clk);
      t++;
    end
    chk("power stage", {29'h0, e}, {29'h0, power_stage_state});
    chk("fault pin", {31'h0, pin}, {31'h0, fault_indicator_pin_n});
  endtask
  task automatic pulse_missed;
    @(posedge sys_clk);
    zero_cross_missed <= 1'b1;
    @(posedge sys_clk);
    zero_cross_missed <= 1'b0;
  endtask
  task finish_test;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #(50 * 20000);
    num_errors++;
    finish_test;
  end
  initial begin
    {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h21;
    {motor_running, zero_cross_missed, probe_start_rampup, probe_start_rampdown, probe_pulse_cmd} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    measured_speed = 16'h0000;
    lowside_current = 12'h1F4;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    rd(`REG_CTRL, 32'h0, 2'h0);
    rd(`REG_STATUS, 32'h0, 2'h0);
    rd(`REG_SPEED_THR, 32'hFFFFFFFF, 2'h0);
    rd(`REG_SYNC_LIMIT, 32'h10, 2'h0);
    rd(`REG_RETRY_CFG, 32'h64, 2'h0);
    rd(8'h40, 32'h0, 2'h2);
    wr(`REG_SPEED_THR, 32'h3E8);
    wr(`REG_RETRY_CFG, 32'h14);
    motor_running <= 1'b1;
    measured_speed <= 16'h07D0;
    settle(20);
    wst(`STAGE_RUN, 1'b1);
    rd(`REG_STATUS, 32'h0, 2'h0);
    for (m = 0; m < 8; m++) begin
      measured_speed <= 16'h0000;
      wr(`REG_CTRL, 32'h10 | m);
      measured_speed <= 16'h07D0;
      wst(m[2:0] & 3'h3, 1'b0);
      rd(`REG_STATUS, 32'h107, 2'h0);
      if (m < 4) begin
        wr(`REG_CTRL, 32'h80000010 | m);
        settle(5);
        wst(m[2:0], 1'b0);
        @(posedge sys_clk);
        measured_speed <= 16'h0000;
        wr(`REG_CTRL, 32'h80000010 | m);
      end else begin
        @(posedge sys_clk);
        measured_speed <= 16'h0000;
      end
      wst(`STAGE_RUN, 1'b1);
      rd(`REG_STATUS, 32'h0, 2'h0);
    end
    wr(`REG_SYNC_LIMIT, 32'h3);
    wr(`REG_CTRL, 32'h28);
    repeat (2) pulse_missed;
    settle(5);
    rd(`REG_STATUS, 32'h0, 2'h0);
    pulse_missed;
    settle(5);
    wst(`STAGE_RUN, 1'b1);
    rd(`REG_STATUS, 32'h0B, 2'h0);
    wr(`REG_CTRL, 32'h80000028);
    rd(`REG_STATUS, 32'h0, 2'h0);
    wr(`REG_ABSENT_CFG, 32'h0004_0064);
    lowside_current <= 12'h000;
    for (m = 9; m < 16; m += 6) begin
      wr(`REG_CTRL, 32'h40 | m);
      settle(20);
      wst(`STAGE_RUN, 1'b1);
      rd(`REG_STATUS, 32'h0, 2'h0);
    end
    wr(`REG_CTRL, 32'h48);
    settle(20);
    rd(`REG_STATUS, 32'h13, 2'h0);
    lowside_current <= 12'h1F4;
    wr(`REG_CTRL, 32'h80000048);
    rd(`REG_STATUS, 32'h0, 2'h0);
    wr(`REG_CTRL, 32'h200);
    wr(`REG_INT_ENABLE, 32'hA0);
    probe_start_rampup <= 1'b1;
    @(posedge sys_clk);
    probe_start_rampup <= 1'b0;
    settle(60);
    rd(`REG_STATUS, 32'h0, 2'h0);
    chk("irq", 32'h0, {31'h0, irq});
    probe_start_rampdown <= 1'b1;
    @(posedge sys_clk);
    probe_start_rampdown <= 1'b0;
    repeat (3) @(posedge sys_clk);
    probe_pulse_cmd <= 1'b1;
    @(posedge sys_clk);
    probe_pulse_cmd <= 1'b0;
    settle(5);
    rd(`REG_STATUS, 32'h80, 2'h0);
    chk("irq", 32'h1, {31'h0, irq});
    wr(`REG_INT_ENABLE, 32'h0);
    settle(3);
    chk("irq", 32'h0, {31'h0, irq});
    wr(`REG_INT_CLEAR, 32'h80);
    rd(`REG_STATUS, 32'h0, 2'h0);
    wr(`REG_INT_ENABLE, 32'hA0);
    settle(3);
    chk("irq", 32'h0, {31'h0, irq});
    finish_test;
  end
endmodule
`default_nettype wire
